// ===== rtl/rpps_cfg.svh
// Constants for the receive-port page select block.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef RPPS_CFG_SVH
`define RPPS_CFG_SVH
`define RPPS_ADDR_W          8
`define RPPS_DATA_W          8
`define RPPS_NUM_SRC         3
`define RPPS_SRC_LOCAL       2'h0
`define RPPS_SRC_CHAN0       2'h1
`define RPPS_SRC_CHAN1       2'h2
`define RPPS_OFS_LINK_CAP    8'h4a
`define RPPS_OFS_EMBED_CTL   8'h4b
`define RPPS_OFS_PAGE_SEL    8'h4c
`define RPPS_PAGE_LO_A       8'h4d
`define RPPS_PAGE_HI_A       8'h7f
`define RPPS_PAGE_LO_B       8'hd0
`define RPPS_PAGE_HI_B       8'hdf
`define RPPS_EMBED_CTL_RST   8'h12
`define RPPS_EMBED_CNT_HI    7
`define RPPS_EMBED_CNT_LO    6
`define RPPS_EMBED_ID_HI     5
`define RPPS_EMBED_ID_LO     0
`define RPPS_SEL_PHYS_BIT    6
`define RPPS_SEL_READ_BIT    4
`define RPPS_SEL_WR1_BIT     1
`define RPPS_SEL_WR0_BIT     0
`define RPPS_SEL_READ_RST    3'b100
`define RPPS_SEL_WR0_RST     3'b010
`define RPPS_SEL_WR1_RST     3'b100
`define RPPS_RAW10_RST       6'h2b
`define RPPS_RAW12_RST       6'h2c
`endif

// ===== rtl/rpps_page_bank.sv
// Paged register bank for two receive ports with per-source page select.
// Assumes one register access per cycle from an access engine on core_clk_in;
// the source code says which path (local I2C or a back_channel port) carries it.
`timescale 1ns/100ps
`include "rpps_cfg.svh"
module rpps_page_bank
  import rpps_pkg::*;
(
  // Clock and reset
  input  wire logic       core_clk_in,
  input  wire logic       rst_n_in,
  // Register access
  input  wire logic       acc_valid_in,
  input  wire logic       acc_write_in,
  input  wire rpps_src_t  acc_src_in,
  input  wire rpps_addr_t acc_addr_in,
  input  wire rpps_data_t acc_wdata_in,
  output rpps_data_t      acc_rdata_out,
  // Per-port receive configuration
  input  wire logic [1:0] csi_mode_in,
  input  wire logic [1:0] raw12_sel_in,
  input  wire logic [1:0] frame_start_in,
  input  wire logic [1:0] line_start_in,
  output logic      [5:0] port0_data_type_out,
  output logic      [5:0] port1_data_type_out
);
  // Data types from the two marking units, one slice per port
  wire  [1:0][5:0] port_type;
  logic [2:0] sel_read;
  logic [2:0] sel_wr0;
  logic [2:0] sel_wr1;

  wire is_paged = (acc_addr_in == `RPPS_OFS_LINK_CAP) || (acc_addr_in == `RPPS_OFS_EMBED_CTL)
    || (acc_addr_in >= `RPPS_PAGE_LO_A && acc_addr_in <= `RPPS_PAGE_HI_A)
    || (acc_addr_in >= `RPPS_PAGE_LO_B && acc_addr_in <= `RPPS_PAGE_HI_B);
  wire is_sel   = (acc_addr_in == `RPPS_OFS_PAGE_SEL);
  wire [1:0] src_idx  = (acc_src_in > `RPPS_SRC_CHAN1) ? `RPPS_SRC_LOCAL : acc_src_in;
  wire       src_rd   = sel_read[src_idx];
  wire       phys_num = (src_idx == `RPPS_SRC_CHAN1);
  wire       wr_stb   = acc_valid_in && acc_write_in;
  wire [1:0] page_we  = {sel_wr1[src_idx], sel_wr0[src_idx]} & {2{wr_stb && is_paged}};
  wire [1:0] plain_we = {2{wr_stb && !is_paged && !is_sel}};
  // Unpaged storage lives in the port 0 array so every address has one home
  wire [1:0] mem_we   = page_we | {1'b0, plain_we[0]};
  wire rpps_data_t sel_view = {1'b0, phys_num, 1'b0, src_rd, 2'h0,
                               sel_wr1[src_idx], sel_wr0[src_idx]};
  // Reset values per source: local 0, channel N selects port N
  localparam logic [2:0] SEL_READ_RST = `RPPS_SEL_READ_RST;
  localparam logic [2:0] SEL_WR0_RST  = `RPPS_SEL_WR0_RST;
  localparam logic [2:0] SEL_WR1_RST  = `RPPS_SEL_WR1_RST;

  genvar s;
  generate
    for (s = 0; s < `RPPS_NUM_SRC; s = s + 1) begin : g_src
      always_ff @(posedge core_clk_in) begin
        if (!rst_n_in) begin
          sel_read[s] <= SEL_READ_RST[s];
          sel_wr0[s]  <= SEL_WR0_RST[s];
          sel_wr1[s]  <= SEL_WR1_RST[s];
        end else if (wr_stb && is_sel && src_idx == 2'(s)) begin
          sel_read[s] <= acc_wdata_in[`RPPS_SEL_READ_BIT];
          sel_wr0[s]  <= acc_wdata_in[`RPPS_SEL_WR0_BIT];
          sel_wr1[s]  <= acc_wdata_in[`RPPS_SEL_WR1_BIT];
        end
      end
    end
  endgenerate

  genvar p;
  generate
    for (p = 0; p < 2; p = p + 1) begin : g_port
      // Plain memory has no reset; only the embedded control word needs its default
      // Each port owns its store, so no array is written from two processes
      rpps_data_t mem [256];
      logic [7:0] embed_ctl;
      always_ff @(posedge core_clk_in) begin
        if (mem_we[p]) mem[acc_addr_in] <= acc_wdata_in;
      end
      always_ff @(posedge core_clk_in) begin
        if (!rst_n_in) embed_ctl <= `RPPS_EMBED_CTL_RST;
        else if (page_we[p] && acc_addr_in == `RPPS_OFS_EMBED_CTL) embed_ctl <= acc_wdata_in;
      end
      rpps_type_mark u_mark (
        .core_clk_in            (core_clk_in),
        .rst_n_in               (rst_n_in),
        .line_count_sel_in      (embed_ctl[`RPPS_EMBED_CNT_HI:`RPPS_EMBED_CNT_LO]),
        .embedded_type_value_in (embed_ctl[`RPPS_EMBED_ID_HI:`RPPS_EMBED_ID_LO]),
        .raw_type_value_in      (raw12_sel_in[p] ? `RPPS_RAW12_RST : `RPPS_RAW10_RST),
        .csi_mode_in            (csi_mode_in[p]),
        .frame_start_in         (frame_start_in[p]),
        .line_start_in          (line_start_in[p]),
        .data_type_out          (port_type[p])
      );
    end
  endgenerate

  // Reads of the embedded control word come from the reset-bearing copy
  wire rpps_data_t embed_view = src_rd ? g_port[1].embed_ctl : g_port[0].embed_ctl;
  wire rpps_data_t port0_word = g_port[0].mem[acc_addr_in];
  wire rpps_data_t port1_word = g_port[1].mem[acc_addr_in];
  // Unpaged addresses always read the port 0 store
  wire rpps_data_t mem_view   = (is_paged && src_rd) ? port1_word : port0_word;
  wire rpps_data_t next_rdata = is_sel ? sel_view : mem_view;
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) acc_rdata_out <= 8'h00;
    else if (acc_valid_in && !acc_write_in)
      acc_rdata_out <= (acc_addr_in == `RPPS_OFS_EMBED_CTL) ? embed_view : next_rdata;
  end

  assign port0_data_type_out = port_type[0];
  assign port1_data_type_out = port_type[1];
endmodule // rpps_page_bank

// ===== rtl/rpps_pkg.sv
// Types for the receive-port page select block.
// Assumes rpps_cfg.svh is on the include path.
`include "rpps_cfg.svh"
package rpps_pkg;
  typedef logic [`RPPS_ADDR_W-1:0] rpps_addr_t;
  typedef logic [`RPPS_DATA_W-1:0] rpps_data_t;
  typedef logic [1:0]              rpps_src_t;
  typedef enum logic [1:0] {RPPS_LINE_IDLE, RPPS_LINE_EMBED, RPPS_LINE_VIDEO} rpps_line_t;
endpackage

// ===== rtl/rpps_type_mark.sv
// Per-port data type rewrite for the first lines of a raw-mode frame.
// Assumes frame and line strobes are one-cycle pulses on core_clk_in.
`timescale 1ns/100ps
`include "rpps_cfg.svh"
module rpps_type_mark
  import rpps_pkg::*;
(
  // Clock and reset
  input  wire logic       core_clk_in,
  input  wire logic       rst_n_in,
  // Configuration
  input  wire logic [1:0] line_count_sel_in,
  input  wire logic [5:0] embedded_type_value_in,
  input  wire logic [5:0] raw_type_value_in,
  input  wire logic       csi_mode_in,
  // Frame timing
  input  wire logic       frame_start_in,
  input  wire logic       line_start_in,
  // Result
  output logic      [5:0] data_type_out
);
  logic [1:0] lines_seen;
  rpps_line_t state;
  rpps_line_t next_state;
  wire        raw_active = !csi_mode_in && (line_count_sel_in != 2'h0);
  wire        embed_now  = raw_active && (lines_seen < line_count_sel_in);

  always_comb begin
    case (state)
      RPPS_LINE_IDLE:  next_state = line_start_in ? (embed_now ? RPPS_LINE_EMBED : RPPS_LINE_VIDEO)
                                                  : RPPS_LINE_IDLE;
      RPPS_LINE_EMBED: next_state = line_start_in ? (embed_now ? RPPS_LINE_EMBED : RPPS_LINE_VIDEO)
                                                  : RPPS_LINE_EMBED;
      RPPS_LINE_VIDEO: next_state = RPPS_LINE_VIDEO;
      default:         next_state = RPPS_LINE_IDLE;
    endcase
    if (frame_start_in) next_state = RPPS_LINE_IDLE;
  end

  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      state         <= RPPS_LINE_IDLE;
      lines_seen    <= 2'h0;
      data_type_out <= 6'h00;
    end else begin
      state <= next_state;
      if (frame_start_in) lines_seen <= 2'h0;
      else if (line_start_in && lines_seen != 2'h3) lines_seen <= lines_seen + 2'h1;
      if (line_start_in)
        data_type_out <= embed_now ? embedded_type_value_in : raw_type_value_in;
    end
  end
endmodule // rpps_type_mark

// ===== verif/rpps_host_model.sv
// Host side model: one register access at a time.
// Assumes read data is registered at the taken edge.
`timescale 1ns/100ps
module rpps_host_model
  import rpps_pkg::*;
(
  input  wire logic       core_clk_in,
  input  wire rpps_data_t rdata_in,
  output logic            valid_out,
  output logic            write_out,
  output rpps_src_t       src_out,
  output rpps_addr_t      addr_out,
  output rpps_data_t      wdata_out
);
  initial begin
    valid_out = 1'b0;
    write_out = 1'b0;
    src_out   = 2'h0;
    addr_out  = 8'h00;
    wdata_out = 8'h00;
  end
  // Released address and data lines are inverted so stale values never pass for a live request
  task automatic xfer(input rpps_src_t s, input logic w, input rpps_addr_t a,
                      input rpps_data_t d, output rpps_data_t q);
    @(posedge core_clk_in);
    #1 {valid_out, write_out, src_out, addr_out, wdata_out} = {1'b1, w, s, a, d};
    @(posedge core_clk_in);
    #1 {valid_out, addr_out, wdata_out} = {1'b0, ~a, ~d};
    @(posedge core_clk_in);
    #1 q = rdata_in;
  endtask
endmodule // rpps_host_model

// ===== verif/rpps_monitor.sv
// Port checker for the page select bank.
// Assumes it is bound to rpps_page_bank.
`timescale 1ns/100ps
module rpps_monitor
  import rpps_pkg::*;
(
  input  wire logic       core_clk_in,
  input  wire logic       rst_n_in,
  input  wire logic       acc_valid_in,
  input  wire logic       acc_write_in,
  input  wire rpps_src_t  acc_src_in,
  input  wire rpps_addr_t acc_addr_in,
  input  wire rpps_data_t acc_rdata_out,
  input  wire logic [1:0] csi_mode_in,
  input  wire logic [1:0] raw12_sel_in,
  input  wire logic [1:0] line_start_in,
  input  wire logic [5:0] port0_data_type_out,
  input  wire logic [5:0] port1_data_type_out
);
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!rst_n_in);
  wire rd     = acc_valid_in && !acc_write_in;
  wire sel_rd = rd && (acc_addr_in == 8'h4c);
  a_phys_zero: assert property (sel_rd && acc_src_in != 2'h2 |=> !acc_rdata_out[6])
    else $error("carrier port bit set");
  a_phys_one: assert property (sel_rd && acc_src_in == 2'h2 |=> acc_rdata_out[6])
    else $error("carrier port bit clear");
  a_sel_reserved: assert property (sel_rd |=> (acc_rdata_out & 8'hac) == 8'h00)
    else $error("reserved select bits set");
  a_rdata_hold: assert property (!rd |=> $stable(acc_rdata_out))
    else $error("read data moved without a read");
  a_csi_raw0: assert property (line_start_in[0] && csi_mode_in[0] |=>
    port0_data_type_out == ($past(raw12_sel_in[0]) ? 6'h2c : 6'h2b))
    else $error("port 0 marked in csi mode");
  a_csi_raw1: assert property (line_start_in[1] && csi_mode_in[1] |=>
    port1_data_type_out == ($past(raw12_sel_in[1]) ? 6'h2c : 6'h2b))
    else $error("port 1 marked in csi mode");
  a_type_hold0: assert property (!line_start_in[0] |=> $stable(port0_data_type_out))
    else $error("port 0 type moved between lines");
  a_type_hold1: assert property (!line_start_in[1] |=> $stable(port1_data_type_out))
    else $error("port 1 type moved between lines");
endmodule // rpps_monitor
bind rpps_page_bank rpps_monitor rpps_monitor_i (.*);

// ===== verif/rpps_page_bank_tb_top.sv
// Self-checking bench for the page select bank.
// Assumes the host model and the bound checker are compiled first.
`timescale 1ns/100ps
module rpps_page_bank_tb_top
  import rpps_pkg::*;
;
  logic       core_clk_in = 1'b0;
  logic       rst_n_in    = 1'b0;
  logic       acc_valid, acc_write;
  rpps_src_t  acc_src;
  rpps_addr_t acc_addr;
  rpps_data_t acc_wdata, acc_rdata, q;
  logic [1:0] csi_mode = 2'b10, raw12_sel = 2'b10, frame_start = 2'b00, line_start = 2'b00;
  logic [5:0] type0, type1;
  int         n_mismatch = 0, comparisons = 0;
  always #12.5 core_clk_in = ~core_clk_in;
  rpps_page_bank rpps_page_bank_i (.core_clk_in, .rst_n_in, .acc_valid_in(acc_valid),
    .acc_write_in(acc_write), .acc_src_in(acc_src), .acc_addr_in(acc_addr),
    .acc_wdata_in(acc_wdata), .acc_rdata_out(acc_rdata), .csi_mode_in(csi_mode),
    .raw12_sel_in(raw12_sel), .frame_start_in(frame_start), .line_start_in(line_start),
    .port0_data_type_out(type0), .port1_data_type_out(type1));
  rpps_host_model rpps_host_model_i (.core_clk_in, .rdata_in(acc_rdata), .valid_out(acc_valid),
    .write_out(acc_write), .src_out(acc_src), .addr_out(acc_addr), .wdata_out(acc_wdata));
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input rpps_src_t s, input rpps_addr_t a, input rpps_data_t d);
    rpps_host_model_i.xfer(s, 1'b1, a, d, q);
  endtask
  task automatic rd(input rpps_src_t s, input rpps_addr_t a, input rpps_data_t e);
    rpps_host_model_i.xfer(s, 1'b0, a, 8'h00, q);
    chk(q, e);
  endtask
  task automatic summarize();
    if (n_mismatch == 0 && comparisons > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic t_reset_view();
    rd(2'h0, 8'h4c, 8'h00);
    rd(2'h1, 8'h4c, 8'h01);
    rd(2'h2, 8'h4c, 8'h52);
    rd(2'h0, 8'h4b, 8'h12);
  endtask
  task automatic t_paging();
    rpps_addr_t pa[5] = '{8'h4a, 8'h4d, 8'h7f, 8'hd0, 8'hdf};
    foreach (pa[i]) begin
      wr(2'h0, 8'h4c, 8'h03);
      wr(2'h0, pa[i], 8'h55);
      wr(2'h0, 8'h4c, 8'h01);
      wr(2'h0, pa[i], 8'h99);
      wr(2'h0, 8'h4c, 8'h00);
      wr(2'h0, pa[i], 8'hff);
      rd(2'h0, pa[i], 8'h99);
      wr(2'h0, 8'h4c, 8'hff);
      rd(2'h0, 8'h4c, 8'h13);
      rd(2'h0, pa[i], 8'h55);
    end
    rd(2'h2, 8'h4c, 8'h52);
    // Read select 1 and no write enables must not disturb unpaged bytes
    wr(2'h0, 8'h4c, 8'h10);
    wr(2'h0, 8'h20, 8'h3c);
    wr(2'h0, 8'h80, 8'ha5);
    wr(2'h0, 8'hcf, 8'h5a);
    rd(2'h0, 8'h20, 8'h3c);
    rd(2'h0, 8'h80, 8'ha5);
    rd(2'h0, 8'hcf, 8'h5a);
  endtask
  // Frame and line strobes never share a cycle, so the line count is unambiguous
  task automatic t_marking();
    wr(2'h0, 8'h4c, 8'h03);
    for (int n = 0; n < 5; n++) begin
      if (n == 4) csi_mode = 2'b11;
      wr(2'h0, 8'h4b, {n[1:0] | {2{n[2]}}, 6'h30});
      @(posedge core_clk_in);
      #1 frame_start = 2'b11;
      @(posedge core_clk_in);
      #1 frame_start = 2'b00;
      for (int l = 0; l < 4; l++) begin
        @(posedge core_clk_in);
        #1 line_start = 2'b11;
        @(posedge core_clk_in);
        #1 line_start = 2'b00;
        chk({2'b00, type0}, (n < 4 && l < n) ? 8'h30 : 8'h2b);
        chk({2'b00, type1}, 8'h2c);
      end
    end
  endtask
  // A reset in mid-run must restore the local and channel 1 select copies and the port 0 control word
  task automatic t_rereset();
    wr(2'h3, 8'h4c, 8'h10);
    rd(2'h0, 8'h4c, 8'h10);
    wr(2'h2, 8'h4c, 8'h01);
    rd(2'h2, 8'h4c, 8'h41);
    @(posedge core_clk_in);
    #1 rst_n_in = 1'b0;
    repeat (2) @(posedge core_clk_in);
    #1 rst_n_in = 1'b1;
    chk(acc_rdata, 8'h00);
    chk({2'b00, type0}, 8'h00);
    chk({2'b00, type1}, 8'h00);
    rd(2'h2, 8'h4c, 8'h52);
    rd(2'h0, 8'h4c, 8'h00);
    rd(2'h1, 8'h4b, 8'h12);
  endtask
  initial begin
    repeat (16) @(posedge core_clk_in);
    #1 rst_n_in = 1'b1;
    t_reset_view();
    t_paging();
    t_marking();
    t_rereset();
    summarize();
  end
  initial begin
    repeat (5000) @(posedge core_clk_in);
    n_mismatch++;
    summarize();
  end
endmodule // rpps_page_bank_tb_top
